// file: include/tcrc_consts.vh
/*
  Constants of the timer 2 capture/reload counter: register offsets,
  field positions, reset values, mode codes and machine cycle timing.
  Assumes it is included by its bare name from the design files.
*/
`ifndef TCRC_CONSTS_VH
`define TCRC_CONSTS_VH

// register byte offsets on the bus
`define TCRC_OFS_CONTROL      8'h00
`define TCRC_OFS_MODE         8'h04
`define TCRC_OFS_COUNT_LOW    8'h08
`define TCRC_OFS_COUNT_HIGH   8'h0C
`define TCRC_OFS_CAPTURE_LOW  8'h10
`define TCRC_OFS_CAPTURE_HIGH 8'h14

// timer_control_reg bit positions
`define TCRC_BIT_OVERFLOW     7
`define TCRC_BIT_EXTERNAL     6
`define TCRC_BIT_RX_CLOCK     5
`define TCRC_BIT_TX_CLOCK     4
`define TCRC_BIT_EXT_ENABLE   3
`define TCRC_BIT_RUN          2
`define TCRC_BIT_COUNTER_SEL  1
`define TCRC_BIT_CAPTURE_SEL  0

// timer_mode_reg bit positions
`define TCRC_BIT_DOWN_ENABLE  0

// reset values and count constants
`define TCRC_RST_BYTE         8'h00
`define TCRC_RST_WORD         16'h0000
`define TCRC_RST_DATA         32'h0000_0000
`define TCRC_ALL_ONES         16'hFFFF
`define TCRC_ONE              16'h0001

// operating modes
`define TCRC_MODE_OFF         2'h0
`define TCRC_MODE_RELOAD      2'h1
`define TCRC_MODE_CAPTURE     2'h2
`define TCRC_MODE_BAUD        2'h3

// machine cycle timing, in oscillator periods of I_MCLK
`define TCRC_OSC_PER_MC       12
`define TCRC_IDX_STATE5_PHASE2         4'h9
`define TCRC_IDX_STATE3_PHASE1         4'h4
`define TCRC_IDX_ZERO         4'h0
`define TCRC_IDX_ONE          4'h1

`endif

// file: tb/tb_tcrc_top.sv
/*
  Self-checking bench of the timer 2 block: Wishbone tasks, pin partner, read notes in a queue.
  Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module tb_tcrc_top;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ctrl = 1, start = 0, slow = 0;
  logic [7:0]  adr = 8'h00, edges = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [15:0] expq[$];
  logic [15:0] note, v;
  wire  [31:0] rdat;
  wire         ack, irq, rxt, txt, cpin, xpin, busy;
  int          bad_count = 0, tests_run = 0, ticks[2] = '{0, 0};

  // 100 MHz oscillator
  always #5 clk = ~clk;

  tcrc_top dut_u (.I_MCLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_COUNT_INPUT_PIN(cpin),
    .I_EXTERNAL_CONTROL_PIN(xpin), .O_IRQ(irq), .O_RX_BAUD_TICK(rxt), .O_TX_BAUD_TICK(txt));
  tcrc_pin_src src_u (.i_clk(clk), .i_reset(rst), .i_start(start), .i_slow(slow), .i_ctrl(ctrl),
    .i_edges(edges), .o_count_pin(cpin), .o_ctrl_pin(xpin), .o_busy(busy));

  task automatic summarize;
    $display("tests %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] lo, hi, got);
    tests_run++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      bad_count++;
      $display("ERROR %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, d);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    if (n >= 50) begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic rd(input logic [7:0] a, e);
    expq.push_back({e, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d[7:0]);
    bus(1'b1, a + 8'h04, d[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a + 8'h04, e[15:8]);
  endtask

  // n falling events on the count pin, bounded wait for the partner
  task automatic pulses(input logic [7:0] n);
    int k = 0;
    edges <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(posedge clk);
      k++;
    end while (busy === 1'b1 && k < 3000);
    if (k >= 3000) begin
      bad_count++;
      summarize();
    end
    repeat (24) @(posedge clk);
  endtask

  // control pin low then high, each level long enough to be sampled
  task automatic fall;
    ctrl <= 1'b0;
    repeat (30) @(posedge clk);
    ctrl <= 1'b1;
    repeat (30) @(posedge clk);
  endtask

  // oldest read note against the returned byte; baud ticks counted
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      note = expq.pop_front();
      chk($sformatf("reg %h", adr), {8'h00, note[15:8]}, {8'h00, note[7:0]}, rdat[15:0]);
    end
    if (txt === 1'b1) ticks[0]++;
    if (rxt === 1'b1) ticks[1]++;
  end

  initial begin
    v = $urandom(26553);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 8'h18, 8'hFF);
    for (int a = 0; a <= 24; a += 4) rd(a[7:0], 8'h00);
    $display("reset test done");
    bus(1'b1, 8'h00, 8'h04);
    repeat (240) @(posedge clk);
    bus(1'b1, 8'h00, 8'h00);
    expq.push_back(16'h1315);
    bus(1'b0, 8'h08, 8'h00);
    rd(8'h0C, 8'h00);
    $display("timer rate test done");
    for (int s = 0; s < 2; s++) begin
      wr16(8'h10, 16'hFFF0);
      wr16(8'h08, 16'hFFF0);
      ticks = '{0, 0};
      bus(1'b1, 8'h00, s ? 8'h2C : 8'h1C);
      repeat (320) @(posedge clk);
      chk("baud ticks", 16'h0009, 16'h000B, ticks[s][15:0]);
      chk("other ticks", 16'h0000, 16'h0000, ticks[1 - s][15:0]);
      fall();
      rd(8'h00, s ? 8'h6C : 8'h5C);
      chk("irq", 16'h0001, 16'h0001, {15'h0000, irq});
      bus(1'b1, 8'h00, 8'h00);
      repeat (3) @(posedge clk);
      chk("irq", 16'h0000, 16'h0000, {15'h0000, irq});
    end
    $display("baud test done");
    v = v & 16'h7FFF;
    wr16(8'h08, v);
    bus(1'b1, 8'h00, 8'h0F);
    fall();
    rd(8'h00, 8'h4F);
    chk("irq", 16'h0001, 16'h0001, {15'h0000, irq});
    rd16(8'h10, v);
    slow <= 1'b1;
    pulses(8'h03);
    slow <= 1'b0;
    rd16(8'h08, v + 16'h0003);
    bus(1'b1, 8'h00, 8'h00);
    wr16(8'h08, 16'hFFFE);
    bus(1'b1, 8'h00, 8'h07);
    pulses(8'h02);
    rd16(8'h08, 16'h0000);
    rd(8'h00, 8'h87);
    $display("capture test done");
    bus(1'b1, 8'h00, 8'h00);
    wr16(8'h10, 16'hAB00);
    wr16(8'h08, 16'hFFFF);
    bus(1'b1, 8'h00, 8'h06);
    pulses(8'h01);
    rd16(8'h08, 16'hAB00);
    rd(8'h00, 8'h86);
    bus(1'b1, 8'h00, 8'h0E);
    wr16(8'h08, 16'h0011);
    fall();
    rd16(8'h08, 16'hAB00);
    rd(8'h00, 8'h4E);
    $display("reload test done");
    bus(1'b1, 8'h00, 8'h00);
    bus(1'b1, 8'h04, 8'h01);
    wr16(8'h10, 16'h0010);
    wr16(8'h08, 16'h0011);
    ctrl <= 1'b0;
    bus(1'b1, 8'h00, 8'h06);
    pulses(8'h02);
    rd16(8'h08, 16'hFFFF);
    rd(8'h00, 8'hC6);
    bus(1'b1, 8'h00, 8'h46);
    repeat (3) @(posedge clk);
    chk("irq", 16'h0000, 16'h0000, {15'h0000, irq});
    ctrl <= 1'b1;
    repeat (30) @(posedge clk);
    pulses(8'h01);
    rd16(8'h08, 16'h0010);
    rd(8'h00, 8'h86);
    $display("up down test done");
    summarize();
  end
endmodule // tb_tcrc_top

// file: tb/tcrc_pin_src.sv
/*
  Pin partner of the timer 2 block: falling events on the count input, a level on the control input.
  Assumes the block's clock; every count pin level lasts whole machine cycles.
*/
`timescale 1ns/1ps
module tcrc_pin_src (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_start,
  input  wire logic       i_slow,
  input  wire logic       i_ctrl,
  input  wire logic [7:0] i_edges,
  output logic            o_count_pin = 1'b1,
  output logic            o_ctrl_pin = 1'b1,
  output logic            o_busy = 1'b0
);
  logic [7:0] left = 8'h00;
  logic [5:0] t = 6'h00;

  // each half lasts one or three machine cycles so no level goes unsampled
  always @(posedge i_clk) begin
    o_ctrl_pin <= i_ctrl;
    if (i_reset) begin
      o_count_pin <= 1'b1;
      o_busy <= 1'b0;
      t <= 6'h00;
    end else if (i_start && !o_busy) begin
      left <= i_edges;
      t <= 6'h00;
      o_busy <= (i_edges != 8'h00);
    end else if (o_busy && t == (i_slow ? 6'h23 : 6'h0B)) begin
      t <= 6'h00;
      o_count_pin <= ~o_count_pin;
      if (!o_count_pin) begin
        left <= left - 8'h01;
        o_busy <= (left != 8'h01);
      end
    end else if (o_busy) begin
      t <= t + 6'h01;
    end
  end
endmodule // tcrc_pin_src

// file: tb/tcrc_properties.sv
/*
  Checker of the timer 2 block: bus handshake, read data, baud ticks, request line.
  Assumes it is bound to tcrc_top and sees only its ports.
*/
`timescale 1ns/1ps
module tcrc_properties (
  input wire logic        I_MCLK,
  input wire logic        I_RESET,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic        O_IRQ,
  input wire logic        O_RX_BAUD_TICK,
  input wire logic        O_TX_BAUD_TICK
);
  // one domain; reset masks all but the reset check
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);

  a_ack_next_edge: assert property ($rose(I_WB_CYC && I_WB_STB) |=> O_WB_ACK)
    else $error("ack not one cycle after request");
  a_ack_one_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  a_ack_has_request: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
    else $error("ack without request");
  a_read_upper_zero: assert property (O_WB_DAT[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_read_data_holds: assert property (!O_WB_ACK |-> $stable(O_WB_DAT))
    else $error("read data moved without ack");
  a_tx_tick_pulse: assert property (O_TX_BAUD_TICK |=> !O_TX_BAUD_TICK)
    else $error("tx tick longer than one cycle");
  a_rx_tick_pulse: assert property (O_RX_BAUD_TICK |=> !O_RX_BAUD_TICK)
    else $error("rx tick longer than one cycle");
  // the request falls only by a software write, two edges after its ack
  a_irq_sw_clear: assert property ($fell(O_IRQ) |-> $past(O_WB_ACK && I_WB_WE, 2))
    else $error("request dropped without a write");
  a_reset_quiet: assert property (disable iff (1'b0) I_RESET |=> !O_WB_ACK && !O_IRQ && !O_TX_BAUD_TICK && !O_RX_BAUD_TICK)
    else $error("outputs not cleared by reset");
endmodule // tcrc_properties

bind tcrc_top tcrc_properties u_props (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_IRQ(O_IRQ),
  .O_RX_BAUD_TICK(O_RX_BAUD_TICK), .O_TX_BAUD_TICK(O_TX_BAUD_TICK));

// file: verilog/tcrc_phase_gen.v
/*
  Machine cycle phase generator: divides the oscillator into machine
  cycles of twelve periods and states of two, and gives one-cycle
  enables at the sampling and update points of each machine cycle.
  Assumes I_MCLK is the oscillator and reset is synchronous.
*/
`timescale 1ns/1ps
`include "tcrc_consts.vh"

module tcrc_phase_gen #(
  parameter OSC_PER_MC = `TCRC_OSC_PER_MC
) (
  input  wire i_clk,
  input  wire i_reset,
  output reg  o_sample_tick,
  output reg  o_update_tick,
  output reg  o_state_tick
);

  // index is four bits wide, enough for up to sixteen periods per cycle
  localparam integer LAST_FULL = OSC_PER_MC - 1;
  localparam [3:0]   LAST_IDX  = LAST_FULL[3:0];

  reg [3:0] phase_idx;
  reg [3:0] next_phase_idx;

  // phase index wraps once per machine cycle
  always @* begin
    if (phase_idx == LAST_IDX) begin
      next_phase_idx = `TCRC_IDX_ZERO;
    end else begin
      next_phase_idx = phase_idx + `TCRC_IDX_ONE;
    end
  end

  // enables are registered so they line up with the index they decode
  always @(posedge i_clk) begin
    if (i_reset) begin
      phase_idx     <= `TCRC_IDX_ZERO;
      o_sample_tick <= 1'b0;
      o_update_tick <= 1'b0;
      o_state_tick  <= 1'b0;
    end else begin
      phase_idx     <= next_phase_idx;
      o_sample_tick <= (next_phase_idx == `TCRC_IDX_STATE5_PHASE2);
      o_update_tick <= (next_phase_idx == `TCRC_IDX_STATE3_PHASE1);
      o_state_tick  <= next_phase_idx[0]; // one per two periods
    end
  end

endmodule // tcrc_phase_gen

// file: verilog/tcrc_top.v
/*
  Timer 2: a 16-bit timer / event counter with capture, up or down
  auto-reload and baud generator modes, reached over classic Wishbone.
  Assumes I_MCLK is the oscillator, pins are synchronous to it, and the
  bus master holds each request until it sees ack.
*/
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tcrc_consts.vh"

// Summary of operation
// RL1 - 16-bit count in two bytes, timer/counter select
// RL2 - timer advances once per machine cycle
// RL3 - mode from run, serial selects, capture select
// RL4 - count pin sampled each cycle, falling counts
// RL5 - new count visible at next cycle's update
// RL6 - two cycles per edge, max rate 1/24
// RL7 - source holds each level one machine cycle
// RL8 - capture mode counts, overflow sets overflow flag
// RL9 - control pin falling edge captures count bytes
// RL10 - capture also sets the external flag
// RL11 - both flags request interrupts when enabled
// RL12 - reset clears down enable; pin picks direction
// RL13 - up reload: overflow flags and reloads count
// RL14 - enabled pin edge forces reload, sets flag
// RL15 - down enabled, pin high: count up, reload
// RL16 - pin low: count down, match loads all ones
// RL17 - external flag toggles, no interrupt then
// RL18 - baud mode: state rate, reload, no flag
// RL19 - baud mode pin edge flags, no reload
// RL20 - request is OR of flags, software clears
// RL21 - select 0 timer, 1 falling edge counter
// RL22 - hardware reload/capture beats software write
module tcrc_top (
  input  wire        I_MCLK,
  input  wire        I_RESET,
  input  wire        I_WB_CYC,
  input  wire        I_WB_STB,
  input  wire        I_WB_WE,
  input  wire [7:0]  I_WB_ADR,
  input  wire [3:0]  I_WB_SEL,
  input  wire [31:0] I_WB_DAT,
  output reg  [31:0] O_WB_DAT,
  output reg         O_WB_ACK,
  input  wire        I_COUNT_INPUT_PIN,
  input  wire        I_EXTERNAL_CONTROL_PIN,
  output reg         O_IRQ,
  output reg         O_RX_BAUD_TICK,
  output reg         O_TX_BAUD_TICK
);

  // software visible state
  reg  [7:0]  count_high_byte;
  reg  [7:0]  count_low_byte;
  reg  [7:0]  capture_reload_high;
  reg  [7:0]  capture_reload_low;
  reg         overflow_flag;
  reg         external_flag;
  reg         serial_rx_clock_select;
  reg         serial_tx_clock_select;
  reg         external_enable;
  reg         run_bit;
  reg         timer_counter_select;
  reg         capture_reload_select;
  reg         down_count_enable;

  // pin sampling state; samples reset low so a pin idling high never
  // shows a false falling edge right after reset
  reg         count_pin_sample;
  reg         count_pending;
  reg         ext_pin_sample;

  // next values
  reg  [15:0] next_count;
  reg  [15:0] next_capture;
  reg         next_overflow;
  reg         next_external;
  reg         rollover;
  reg  [1:0]  mode;
  reg  [31:0] next_rd_data;

  wire        sample_tick;
  wire        update_tick;
  wire        state_tick;

  wire [15:0] count_word   = {count_high_byte, count_low_byte};
  wire [15:0] capture_word = {capture_reload_high, capture_reload_low};
  wire [7:0]  wr_byte      = I_WB_DAT[7:0];

  wire [7:0]  control_byte = {overflow_flag, external_flag, serial_rx_clock_select,
                              serial_tx_clock_select, external_enable, run_bit,
                              timer_counter_select, capture_reload_select};

  tcrc_phase_gen #(
    .OSC_PER_MC (`TCRC_OSC_PER_MC)
  ) u_phase (
    .i_clk         (I_MCLK),
    .i_reset       (I_RESET),
    .o_sample_tick (sample_tick),
    .o_update_tick (update_tick),
    .o_state_tick  (state_tick)
  );

  // bus decode: a write lands on the edge at which ack is seen high
  wire bus_req   = I_WB_CYC & I_WB_STB;
  wire bus_wr    = bus_req & I_WB_WE & O_WB_ACK & I_WB_SEL[0];
  wire wr_ctrl   = bus_wr & (I_WB_ADR == `TCRC_OFS_CONTROL);
  wire wr_mode   = bus_wr & (I_WB_ADR == `TCRC_OFS_MODE);
  wire wr_cnt_lo = bus_wr & (I_WB_ADR == `TCRC_OFS_COUNT_LOW);
  wire wr_cnt_hi = bus_wr & (I_WB_ADR == `TCRC_OFS_COUNT_HIGH);
  wire wr_cap_lo = bus_wr & (I_WB_ADR == `TCRC_OFS_CAPTURE_LOW);
  wire wr_cap_hi = bus_wr & (I_WB_ADR == `TCRC_OFS_CAPTURE_HIGH);
  wire cnt_wr    = wr_cnt_lo | wr_cnt_hi;

  // either serial select turns the timer into a baud generator
  wire serial_sel = serial_rx_clock_select | serial_tx_clock_select;

  // mode table
  always @* begin
    if (!run_bit) begin
      mode = `TCRC_MODE_OFF; // RL3
    end else if (serial_sel) begin
      mode = `TCRC_MODE_BAUD; // RL3
    end else if (capture_reload_select) begin
      mode = `TCRC_MODE_CAPTURE; // RL3
    end else begin
      mode = `TCRC_MODE_RELOAD; // RL3
    end
  end

  // falling edge on the count pin: last sample high, pin low now; only
  // meaningful on a sample tick, so it is always qualified by one
  wire count_fall = count_pin_sample & ~I_COUNT_INPUT_PIN;

  // pin samples are taken once per machine cycle; a pin held less than
  // a full machine cycle may be missed entirely
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      count_pin_sample <= 1'b0;
      ext_pin_sample   <= 1'b0;
      count_pending    <= 1'b0;
    end else begin
      if (sample_tick) begin
        count_pin_sample <= I_COUNT_INPUT_PIN; // RL4 RL7
        ext_pin_sample   <= I_EXTERNAL_CONTROL_PIN;
      end
      // edge seen after one sample, applied at the next update point; the
      // update comes seven clocks after the sample and five before the next
      // one, so at most one edge is ever pending
      if (update_tick) begin
        count_pending <= 1'b0;
      end else if (sample_tick & count_fall) begin
        count_pending <= 1'b1; // RL4 RL6
      end
    end
  end

  // one-cycle increment request
  reg inc;
  always @* begin
    if (timer_counter_select) begin
      inc = update_tick & count_pending; // RL5 RL21
    end else if (mode == `TCRC_MODE_BAUD) begin
      inc = state_tick; // RL18
    end else begin
      inc = update_tick; // RL2 RL21
    end
  end

  // external event: falling edge of the control pin while enabled
  // a low held under one machine cycle may go unseen
  wire ext_fall  = sample_tick & ext_pin_sample & ~I_EXTERNAL_CONTROL_PIN;
  wire ext_event = ext_fall & external_enable & run_bit;

  // direction only matters in reload mode with down counting enabled
  // it comes from the last sample, so a change on the control pin steers
  // the count only from the next machine cycle on
  wire updown    = down_count_enable & (mode == `TCRC_MODE_RELOAD);
  wire count_up  = ~updown | ext_pin_sample;

  // software writes first, then hardware reloads, captures and flag sets override them; an increment gives way to a count write
  always @* begin
    next_count    = count_word;
    next_capture  = capture_word;
    next_overflow = overflow_flag;
    next_external = external_flag;
    rollover      = 1'b0;
    if (wr_cnt_lo) begin
      next_count[7:0] = wr_byte;
    end
    if (wr_cnt_hi) begin
      next_count[15:8] = wr_byte;
    end
    if (wr_cap_lo) begin
      next_capture[7:0] = wr_byte;
    end
    if (wr_cap_hi) begin
      next_capture[15:8] = wr_byte;
    end
    if (wr_ctrl) begin
      next_overflow = wr_byte[`TCRC_BIT_OVERFLOW]; // RL20
      next_external = wr_byte[`TCRC_BIT_EXTERNAL]; // RL20
    end
    // reloads, captures and flag sets below override the writes above; an increment gives way to a count write
    case (mode)
      `TCRC_MODE_CAPTURE: begin
        if (inc & ~cnt_wr) begin
          next_count = count_word + `TCRC_ONE; // RL1
        end
        if (inc & (count_word == `TCRC_ALL_ONES)) begin
          next_overflow = 1'b1; // RL8
        end
        if (ext_event) begin
          next_capture  = count_word; // RL9 RL22
          next_external = 1'b1; // RL10
        end
      end
      `TCRC_MODE_RELOAD: begin
        if (updown) begin
          if (inc & count_up) begin
            if (count_word == `TCRC_ALL_ONES) begin
              next_count    = capture_word; // RL15 RL22
              next_overflow = 1'b1; // RL15
              next_external = ~external_flag; // RL17
            end else if (~cnt_wr) begin
              next_count = count_word + `TCRC_ONE; // RL15
            end
          end else if (inc) begin
            if (count_word == capture_word) begin
              next_count    = `TCRC_ALL_ONES; // RL16 RL22
              next_overflow = 1'b1; // RL16
              next_external = ~external_flag; // RL17
            end else if (~cnt_wr) begin
              next_count = count_word - `TCRC_ONE; // RL16
            end
          end
        end else begin
          if (inc & (count_word == `TCRC_ALL_ONES)) begin
            next_count    = capture_word; // RL13 RL22
            next_overflow = 1'b1; // RL13
          end else if (inc & ~cnt_wr) begin
            next_count = count_word + `TCRC_ONE; // RL13
          end
          if (ext_event) begin
            next_count    = capture_word; // RL14 RL22
            next_external = 1'b1; // RL14
          end
        end
      end
      `TCRC_MODE_BAUD: begin
        // rollover reloads but never touches the overflow flag
        if (inc & (count_word == `TCRC_ALL_ONES)) begin
          next_count = capture_word; // RL18 RL22
          rollover   = 1'b1; // RL18
        end else if (inc & ~cnt_wr) begin
          next_count = count_word + `TCRC_ONE; // RL18
        end
        if (ext_event) begin
          next_external = 1'b1; // RL19
        end
      end
      default: begin
        rollover = 1'b0; // stopped: only software writes
      end
    endcase
  end

  // counter, capture and control state
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      count_high_byte        <= `TCRC_RST_BYTE;
      count_low_byte         <= `TCRC_RST_BYTE;
      capture_reload_high    <= `TCRC_RST_BYTE;
      capture_reload_low     <= `TCRC_RST_BYTE;
      overflow_flag          <= 1'b0;
      external_flag          <= 1'b0;
      serial_rx_clock_select <= 1'b0;
      serial_tx_clock_select <= 1'b0;
      external_enable        <= 1'b0;
      run_bit                <= 1'b0;
      timer_counter_select   <= 1'b0;
      capture_reload_select  <= 1'b0;
      down_count_enable      <= 1'b0; // RL12
    end else begin
      count_high_byte     <= next_count[15:8];
      count_low_byte      <= next_count[7:0];
      capture_reload_high <= next_capture[15:8];
      capture_reload_low  <= next_capture[7:0];
      overflow_flag       <= next_overflow;
      external_flag       <= next_external;
      if (wr_ctrl) begin
        serial_rx_clock_select <= wr_byte[`TCRC_BIT_RX_CLOCK];
        serial_tx_clock_select <= wr_byte[`TCRC_BIT_TX_CLOCK];
        external_enable        <= wr_byte[`TCRC_BIT_EXT_ENABLE];
        run_bit                <= wr_byte[`TCRC_BIT_RUN];
        timer_counter_select   <= wr_byte[`TCRC_BIT_COUNTER_SEL];
        capture_reload_select  <= wr_byte[`TCRC_BIT_CAPTURE_SEL];
      end
      if (wr_mode) begin
        down_count_enable <= wr_byte[`TCRC_BIT_DOWN_ENABLE]; // RL12
      end
    end
  end

  // request follows the flags one cycle late, from a flop; the external
  // flag is a count bit, not a request, while counting up and down
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_IRQ          <= 1'b0;
      O_RX_BAUD_TICK <= 1'b0;
      O_TX_BAUD_TICK <= 1'b0;
    end else begin
      O_IRQ          <= overflow_flag | (external_flag & ~updown); // RL11 RL17 RL20
      O_RX_BAUD_TICK <= rollover & serial_rx_clock_select; // RL18
      O_TX_BAUD_TICK <= rollover & serial_tx_clock_select; // RL18
    end
  end

  // read data mux; unmapped offsets read as zero
  // reads have no side effects; flags clear only by writing zero, except the external flag, which also toggles while counting up and down
  always @* begin
    next_rd_data = `TCRC_RST_DATA;
    case (I_WB_ADR)
      `TCRC_OFS_CONTROL:      next_rd_data[7:0] = control_byte;
      `TCRC_OFS_MODE:         next_rd_data[`TCRC_BIT_DOWN_ENABLE] = down_count_enable;
      `TCRC_OFS_COUNT_LOW:    next_rd_data[7:0] = count_low_byte;
      `TCRC_OFS_COUNT_HIGH:   next_rd_data[7:0] = count_high_byte;
      `TCRC_OFS_CAPTURE_LOW:  next_rd_data[7:0] = capture_reload_low;
      `TCRC_OFS_CAPTURE_HIGH: next_rd_data[7:0] = capture_reload_high;
      default:                next_rd_data      = `TCRC_RST_DATA;
    endcase
  end

  // single wait state slave: ack one cycle after the request, dropped
  // the cycle after; every address is answered so no master hangs
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= `TCRC_RST_DATA;
    end else begin
      O_WB_ACK <= bus_req & ~O_WB_ACK;
      if (bus_req & ~O_WB_ACK & ~I_WB_WE) begin
        O_WB_DAT <= next_rd_data;
      end
    end
  end

endmodule // tcrc_top
